// ### rtl/sps_fifo.sv
/*
 * Synchronous FIFO with valid/ready on both sides.
 * Assumes DEPTH is a power of two and one clock for both sides.
 */
`timescale 1ns/1ps
`default_nettype none
module sps_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic             clk_i,
    input  wire logic             nrst_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);

    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW:0]      wr_ptr_reg;
    logic [AW:0]      rd_ptr_reg;
    logic             full;
    logic             empty;
    logic             push;
    logic             pop;

    assign full  = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) &&
                   (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
    assign empty = (wr_ptr_reg == rd_ptr_reg);
    assign push  = in_valid_i && !full;
    assign pop   = out_ready_i && !empty;

    assign in_ready_o  = !full;
    assign out_valid_o = !empty;
    assign out_data_o  = mem_reg[rd_ptr_reg[AW-1:0]];

    // Storage has no reset; only the pointers define what is valid
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_reg[wr_ptr_reg[AW-1:0]] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            wr_ptr_reg <= '0;
        end else if (push) begin
            wr_ptr_reg <= wr_ptr_reg + (AW+1)'(1);
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rd_ptr_reg <= '0;
        end else if (pop) begin
            rd_ptr_reg <= rd_ptr_reg + (AW+1)'(1);
        end
    end

endmodule
`default_nettype wire

// ### rtl/sps_pkg.sv
/*
 * Constants shared by the serial peripheral slave engine: byte framing,
 * transmit queue sizing and reset values.
 * Assumes a single system clock domain plus the master's serial clock.
 */
package sps_pkg;

    localparam int          BYTE_BITS    = 8;
    localparam int          BITCNT_W     = 3;
    localparam int          TX_DEPTH     = 16;
    localparam int          SYNC_STAGES  = 2;

    localparam logic [2:0]  BITCNT_FIRST = 3'h0;
    localparam logic [2:0]  BITCNT_LAST  = 3'h7;
    localparam logic [2:0]  BITCNT_STEP  = 3'h1;

    localparam logic [7:0]  RX_RESET     = 8'h00;
    localparam logic [7:0]  TX_IDLE_WORD = 8'h00;

    localparam int          MSB          = BYTE_BITS - 1;

endpackage

// ### rtl/sps_slave.sv
/*
 * Serial peripheral slave engine. The external master's serial clock
 * clocks the shift logic; received bytes and transmit words cross into
 * and out of the system clock domain by toggle and stable-hold schemes.
 * Assumes the master keeps each serial clock phase at least five system
 * clocks long and idles the clock between bytes.
 */
`timescale 1ns/1ps
`default_nettype none
module sps_slave #(
    parameter int TX_DEPTH = sps_pkg::TX_DEPTH
) (
    input  wire logic       clk_i,
    input  wire logic       nrst_i,
    input  wire logic       sck_i,
    input  wire logic       mosi_i,
    output logic            miso_o,
    output logic            miso_oe_o,
    input  wire logic       unit_enable_i,
    input  wire logic       master_mode_i,
    input  wire logic       wr_valid_i,
    output logic            wr_ready_o,
    input  wire logic [7:0] wr_data_i,
    output logic      [7:0] rd_data_o,
    output logic            transfer_done_flag_o,
    input  wire logic       done_clear_i,
    output logic            rx_overrun_o,
    output logic            tx_underrun_o,
    output logic            shreg_full_o,
    output logic            slave_active_o
);

    // Link domain, clocked by the master's serial clock

    logic [2:0] bitcnt_reg;
    logic [6:0] rx_shift_reg;
    logic [6:0] tx_shift_reg;
    logic [7:0] rx_byte_reg;
    logic       done_tgl_reg;

    // System domain

    logic       slave_active_reg;
    logic       done_sync;
    logic       done_seen_reg;
    logic       byte_evt;
    logic [7:0] rd_data_reg;
    logic       flag_reg;
    logic       flag_next;
    logic       overrun_reg;
    logic       overrun_next;
    logic       underrun_reg;
    logic       underrun_next;
    logic [7:0] tx_word_reg;
    logic       full_reg;
    logic       q_valid;
    logic       q_ready;
    logic [7:0] q_data;
    logic       load_word;

    // Bit counter advances on every rising master clock edge and wraps after
    // eight; there is no local source of edges at all.
    always_ff @(posedge sck_i or negedge nrst_i) begin
        if (!nrst_i) begin
            bitcnt_reg <= sps_pkg::BITCNT_FIRST;
        end else begin
            bitcnt_reg <= bitcnt_reg + sps_pkg::BITCNT_STEP;
        end
    end

    // Receive shifter samples the data-in pin on the rising edge
    always_ff @(posedge sck_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rx_shift_reg <= '0;
        end else begin
            rx_shift_reg <= {rx_shift_reg[5:0], mosi_i};
        end
    end

    // Completed byte is held until the eighth edge of the next byte,
    // which gives the system side ample time to take it
    always_ff @(posedge sck_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rx_byte_reg  <= sps_pkg::RX_RESET;
            done_tgl_reg <= 1'b0;
        end else if (bitcnt_reg == sps_pkg::BITCNT_LAST) begin
            rx_byte_reg  <= {rx_shift_reg, mosi_i};
            done_tgl_reg <= !done_tgl_reg;
        end
    end

    // First edge of a byte latches the low bits of the word that waits in
    // the shift-register slot; later edges move the next bit up.
    always_ff @(posedge sck_i or negedge nrst_i) begin
        if (!nrst_i) begin
            tx_shift_reg <= '0;
        end else if (bitcnt_reg == sps_pkg::BITCNT_FIRST) begin
            tx_shift_reg <= tx_word_reg[6:0];
        end else begin
            tx_shift_reg <= {tx_shift_reg[5:0], 1'b0};
        end
    end

    // Between bytes the top bit of the loaded word is already on the pin,
    // so the master samples it on its very first edge. The word is changed
    // by the system side at a byte end, at once on a load into an empty slot even in mid byte, and while the slave is inactive.
    assign miso_o = (bitcnt_reg == sps_pkg::BITCNT_FIRST)
                  ? tx_word_reg[sps_pkg::MSB]
                  : tx_shift_reg[6];
    assign miso_oe_o = slave_active_reg;

    // Slave role follows enable and mode straight from local logic
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            slave_active_reg <= 1'b0;
        end else begin
            slave_active_reg <= unit_enable_i && !master_mode_i;
        end
    end

    // Byte-done toggle crosses as a level; its change is the event
    sps_sync #(
        .WIDTH (1)
    ) u_done_sync (
        .clk_i  (clk_i),
        .nrst_i (nrst_i),
        .d_i    (done_tgl_reg),
        .q_o    (done_sync)
    );

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            done_seen_reg <= 1'b0;
        end else begin
            done_seen_reg <= done_sync;
        end
    end

    assign byte_evt = done_sync ^ done_seen_reg;

    // Receive buffer: the data port only ever shows this copy
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rd_data_reg <= sps_pkg::RX_RESET;
        end else if (byte_evt && slave_active_reg) begin
            rd_data_reg <= rx_byte_reg;
        end
    end

    assign rd_data_o = rd_data_reg;

    // Sticky flags: a new byte in the clearing cycle keeps the flag set
    always_comb begin
        flag_next     = flag_reg && !done_clear_i;
        overrun_next  = overrun_reg && !done_clear_i;
        underrun_next = underrun_reg && !done_clear_i;
        if (byte_evt && slave_active_reg) begin
            flag_next = 1'b1;
            if (flag_reg && !done_clear_i) begin
                overrun_next = 1'b1;
            end
            if (!full_reg) begin
                underrun_next = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            flag_reg     <= 1'b0;
            overrun_reg  <= 1'b0;
            underrun_reg <= 1'b0;
        end else begin
            flag_reg     <= flag_next;
            overrun_reg  <= overrun_next;
            underrun_reg <= underrun_next;
        end
    end

    assign transfer_done_flag_o = flag_reg;
    assign rx_overrun_o         = overrun_reg;
    assign tx_underrun_o        = underrun_reg;

    // Transmit holding buffer; when the shift slot stays full the queue
    // fills and write readiness drops back to the writer
    sps_fifo #(
        .WIDTH (sps_pkg::BYTE_BITS),
        .DEPTH (TX_DEPTH)
    ) u_tx_queue (
        .clk_i       (clk_i),
        .nrst_i      (nrst_i),
        .in_valid_i  (wr_valid_i),
        .in_ready_o  (wr_ready_o),
        .in_data_i   (wr_data_i),
        .out_valid_o (q_valid),
        .out_ready_i (q_ready),
        .out_data_o  (q_data)
    );

    // While the slave is active the slot takes a word at once when empty, or in the same cycle that the
    // end of the current byte is seen when full
    assign q_ready   = slave_active_reg && (!full_reg || byte_evt);
    assign load_word = q_ready && q_valid;

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            tx_word_reg <= sps_pkg::TX_IDLE_WORD;
        end else if (load_word) begin
            tx_word_reg <= q_data;
        end else if (byte_evt || !slave_active_reg) begin
            tx_word_reg <= sps_pkg::TX_IDLE_WORD;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            full_reg <= 1'b0;
        end else if (load_word) begin
            full_reg <= 1'b1;
        end else if (byte_evt || !slave_active_reg) begin
            full_reg <= 1'b0;
        end
    end

    assign shreg_full_o   = full_reg;
    assign slave_active_o = slave_active_reg;

endmodule
`default_nettype wire

// ### rtl/sps_sync.sv
/*
 * Two flip-flop level synchroniser into the system clock domain.
 * Assumes each bit is a level or toggle that changes at most once per
 * few destination clocks.
 */
`timescale 1ns/1ps
`default_nettype none
module sps_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk_i,
    input  wire logic             nrst_i,
    input  wire logic [WIDTH-1:0] d_i,
    output logic      [WIDTH-1:0] q_o
);

    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] q_reg;

    // First stage feeds only the second stage
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            meta_reg <= '0;
            q_reg    <= '0;
        end else begin
            meta_reg <= d_i;
            q_reg    <= meta_reg;
        end
    end

    assign q_o = q_reg;

endmodule
`default_nettype wire

// ### testbench/sps_master_model.sv
/* Serial master model: makes the serial clock from its own 15 ns clock.
   Assumes the caller waits on xfer; the clock idles low between bytes. */
`timescale 1ns/1ps
`default_nettype none
module sps_master_model (
    output logic      sck_o,
    output logic      mosi_o,
    input  wire logic miso_i
);
    logic lclk = 1'b0;
    always #7.5 lclk = ~lclk;
    initial begin
        sck_o  = 1'b0;
        mosi_o = 1'b0;
    end
    // Three link ticks a phase keeps each phase above five system clocks
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            mosi_o = tx[i];
            repeat (3) @(posedge lclk);
            rx[i] = miso_i;
            sck_o = 1'b1;
            repeat (3) @(posedge lclk);
            sck_o = 1'b0;
        end
        // Line no longer valid: show the inverse, not the last bit
        mosi_o = ~mosi_o;
        repeat (4) @(posedge lclk);
    endtask
endmodule
`default_nettype wire

// ### testbench/sps_slave_chk.sv
/* Port checker for sps_slave.
   Assumes the master idles the serial clock between bytes. */
`timescale 1ns/1ps
`default_nettype none
module sps_slave_chk (
    input wire logic       clk_i,
    input wire logic       nrst_i,
    input wire logic       sck_i,
    input wire logic       unit_enable_i,
    input wire logic       master_mode_i,
    input wire logic       wr_valid_i,
    input wire logic       wr_ready_o,
    input wire logic [7:0] rd_data_o,
    input wire logic       transfer_done_flag_o,
    input wire logic       done_clear_i,
    input wire logic       rx_overrun_o,
    input wire logic       shreg_full_o,
    input wire logic       slave_active_o
);
    logic [2:0] ecnt_reg;
    logic [3:0] idle_reg;
    logic       sck_q_reg;
    logic       sck_qq_reg;
    wire        rise = sck_q_reg & ~sck_qq_reg;
    // Own coarse view of the serial clock, only to time the checks
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sck_q_reg  <= 1'b0;
            sck_qq_reg <= 1'b0;
        end else begin
            sck_q_reg  <= sck_i;
            sck_qq_reg <= sck_q_reg;
        end
    end
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ecnt_reg <= 3'h0;
            idle_reg <= 4'hF;
        end else if (rise) begin
            ecnt_reg <= ecnt_reg + 3'h1;
            idle_reg <= 4'h0;
        end else if (idle_reg != 4'hF) begin
            idle_reg <= idle_reg + 4'h1;
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    sequence s_last_edge;
        rise && ecnt_reg == 3'h7;
    endsequence
    sequence s_byte_end;
        ecnt_reg == 3'h0 && idle_reg >= 4'h1 && idle_reg <= 4'h6;
    endsequence
    AST_ACTIVE: assert property ($past(nrst_i) |->
        slave_active_o == $past(unit_enable_i && !master_mode_i))
        else $error("slave role does not follow enable and mode");
    AST_DONE_AFTER_8: assert property (s_last_edge ##0
        (slave_active_o && !transfer_done_flag_o && !done_clear_i)
        |-> ##[1:6] transfer_done_flag_o)
        else $error("done flag missing after eighth edge");
    AST_DONE_AT_BYTE: assert property (
        $rose(transfer_done_flag_o) |-> s_byte_end)
        else $error("done flag rose away from a byte end");
    AST_RD_AT_BYTE: assert property ($changed(rd_data_o)
        |-> s_byte_end)
        else $error("read data changed away from a byte end");
    AST_STICKY: assert property (transfer_done_flag_o &&
        !done_clear_i |=> transfer_done_flag_o)
        else $error("done flag dropped without clear");
    AST_CLEAR: assert property (done_clear_i && idle_reg >= 4'h4
        |=> !transfer_done_flag_o && !rx_overrun_o)
        else $error("clear did not drop the flags");
    AST_LOAD: assert property (wr_valid_i && wr_ready_o &&
        slave_active_o && !shreg_full_o && idle_reg == 4'hF
        |-> ##[2:3] shreg_full_o)
        else $error("write did not reach the empty shift slot");
    AST_HOLD: assert property ($fell(shreg_full_o) &&
        slave_active_o && $past(slave_active_o) |-> s_byte_end)
        else $error("shift slot emptied in mid byte");
endmodule
bind sps_slave sps_slave_chk sps_slave_chk_i (
    .clk_i(clk_i), .nrst_i(nrst_i), .sck_i(sck_i),
    .unit_enable_i(unit_enable_i), .master_mode_i(master_mode_i),
    .wr_valid_i(wr_valid_i), .wr_ready_o(wr_ready_o),
    .rd_data_o(rd_data_o), .transfer_done_flag_o(transfer_done_flag_o),
    .done_clear_i(done_clear_i), .rx_overrun_o(rx_overrun_o),
    .shreg_full_o(shreg_full_o), .slave_active_o(slave_active_o)
);
`default_nettype wire

// ### testbench/sps_slave_tb_top.sv
/* Self-checking bench for sps_slave with the serial master model.
   Assumes design, checker and model are compiled before it. */
`timescale 1ns/1ps
`default_nettype none
module sps_slave_tb_top;
    logic       clk_i = 1'b0;
    logic       nrst_i = 1'b0;
    logic       unit_enable_i = 1'b0;
    logic       master_mode_i = 1'b0;
    logic       wr_valid_i = 1'b0;
    logic [7:0] wr_data_i = 8'h00;
    logic       done_clear_i = 1'b0;
    logic       sck, mosi, miso_o, miso_oe_o, wr_ready_o, shreg_full_o;
    logic       transfer_done_flag_o, rx_overrun_o, tx_underrun_o;
    logic       slave_active_o;
    logic [7:0] rd_data_o, rx;
    wire        miso_line = miso_oe_o ? miso_o : 1'b1;
    int         num_errors = 0;
    int         samples_checked = 0;
    always #4 clk_i = ~clk_i;
    sps_slave sps_slave_i (
        .clk_i(clk_i), .nrst_i(nrst_i), .sck_i(sck), .mosi_i(mosi),
        .miso_o(miso_o), .miso_oe_o(miso_oe_o),
        .unit_enable_i(unit_enable_i), .master_mode_i(master_mode_i),
        .wr_valid_i(wr_valid_i), .wr_ready_o(wr_ready_o),
        .wr_data_i(wr_data_i), .rd_data_o(rd_data_o),
        .transfer_done_flag_o(transfer_done_flag_o),
        .done_clear_i(done_clear_i), .rx_overrun_o(rx_overrun_o),
        .tx_underrun_o(tx_underrun_o), .shreg_full_o(shreg_full_o),
        .slave_active_o(slave_active_o)
    );
    sps_master_model sps_master_model_i (
        .sck_o(sck), .mosi_o(mosi), .miso_i(miso_line)
    );
    task automatic chk(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            $display("BAD %s expected %h seen %h", what, exp, got);
            num_errors++;
        end
    endtask
    task automatic finish_test;
        $display("errors %0d checks %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] d);
        int n;
        @(negedge clk_i);
        wr_valid_i = 1'b1;
        wr_data_i = d;
        n = 0;
        while (wr_ready_o !== 1'b1 && n < 50) begin
            @(negedge clk_i);
            n++;
        end
        if (wr_ready_o !== 1'b1) begin
            $display("BAD wr_ready expected 1 seen %b", wr_ready_o);
            num_errors++;
        end
        @(negedge clk_i);
        wr_valid_i = 1'b0;
    endtask
    task automatic clear_done;
        @(negedge clk_i);
        done_clear_i = 1'b1;
        @(negedge clk_i);
        done_clear_i = 1'b0;
        @(negedge clk_i);
    endtask
    task automatic t_fill;
        for (int i = 0; i < 16; i++) wr(8'h10 + 8'(i));
        chk("ready", 8'h00, {7'h0, wr_ready_o});
        chk("oe", 8'h00, {7'h0, miso_oe_o});
        chk("active", 8'h00, {7'h0, slave_active_o});
        unit_enable_i = 1'b1;
        master_mode_i = 1'b1;
        repeat (3) @(negedge clk_i);
        chk("active", 8'h00, {7'h0, slave_active_o});
        chk("full", 8'h00, {7'h0, shreg_full_o});
    endtask
    task automatic t_drain;
        master_mode_i = 1'b0;
        repeat (4) @(negedge clk_i);
        chk("active", 8'h01, {7'h0, slave_active_o});
        chk("oe", 8'h01, {7'h0, miso_oe_o});
        chk("full", 8'h01, {7'h0, shreg_full_o});
        for (int i = 0; i < 16; i++) begin
            sps_master_model_i.xfer(8'hA0 + 8'(i), rx);
            chk("miso", 8'h10 + 8'(i), rx);
            chk("flag", 8'h01, {7'h0, transfer_done_flag_o});
            chk("rd", 8'hA0 + 8'(i), rd_data_o);
            clear_done;
            chk("flag", 8'h00, {7'h0, transfer_done_flag_o});
        end
        chk("full", 8'h00, {7'h0, shreg_full_o});
    endtask
    task automatic t_errors;
        sps_master_model_i.xfer(8'h5A, rx);
        chk("miso", 8'h00, rx);
        chk("under", 8'h01, {7'h0, tx_underrun_o});
        sps_master_model_i.xfer(8'hC3, rx);
        chk("over", 8'h01, {7'h0, rx_overrun_o});
        clear_done;
        chk("over", 8'h00, {7'h0, rx_overrun_o});
        chk("flag", 8'h00, {7'h0, transfer_done_flag_o});
    endtask
    task automatic t_idle_and_reload;
        logic [7:0] keep;
        keep = rd_data_o;
        repeat (40) @(negedge clk_i);
        chk("flag", 8'h00, {7'h0, transfer_done_flag_o});
        chk("rd", keep, rd_data_o);
        wr(8'h3C);
        repeat (2) @(negedge clk_i);
        chk("full", 8'h01, {7'h0, shreg_full_o});
        wr(8'h96);
        sps_master_model_i.xfer(8'h01, rx);
        chk("miso", 8'h3C, rx);
        chk("full", 8'h01, {7'h0, shreg_full_o});
        clear_done;
        sps_master_model_i.xfer(8'h02, rx);
        chk("miso", 8'h96, rx);
        chk("rd", 8'h02, rd_data_o);
    endtask
    // Reset in mid-run with the flag set and a word in the slot
    task automatic t_reset;
        wr(8'h77);
        @(negedge clk_i);
        nrst_i = 1'b0;
        @(negedge clk_i);
        chk("flag", 8'h00, {7'h0, transfer_done_flag_o});
        chk("rd", 8'h00, rd_data_o);
        chk("full", 8'h00, {7'h0, shreg_full_o});
        nrst_i = 1'b1;
        repeat (3) @(negedge clk_i);
        sps_master_model_i.xfer(8'h5A, rx);
        chk("miso", 8'h00, rx);
        chk("rd", 8'h5A, rd_data_o);
    endtask
    initial begin
        #100us;
        num_errors++;
        finish_test;
    end
    initial begin
        repeat (16) @(posedge clk_i);
        chk("ready", 8'h01, {7'h0, wr_ready_o});
        chk("flag", 8'h00, {7'h0, transfer_done_flag_o});
        chk("rd", 8'h00, rd_data_o);
        @(negedge clk_i);
        nrst_i = 1'b1;
        t_fill;
        t_drain;
        t_errors;
        t_idle_and_reload;
        t_reset;
        finish_test;
    end
endmodule
`default_nettype wire
